/* File: hw/pbch_defs.svh */
/*
 Command codes, burst-order field positions and reset values for the bridge command
 policy block. Assumes inclusion by bare name from the policy and bridge design modules.
*/
// How it works
// - Interrupt acknowledge is never issued and never claimed on either bus.
// - Reserved command codes are ignored as target and never driven as master.
// - Special cycles are never claimed, but may be issued on both buses.
// - Config claimed on primary; secondary claims Type-1 writes; primary masters Type-1 writes only.
// - I/O and memory read and write are claimed and issued on both buses.
// - Read multiple, dual address cycle and read line are supported everywhere.
// - Memory write and invalidate is accepted and may be issued on both buses.
// - A 32-bit address uses one phase: address on AD low, command on the four lines above it.
// - Only linear incrementing bursts: both low address bits zero.
// - Nonzero low address bits make the target disconnect after the first transfer.
// - Dual address cycle: second address phase follows exactly one clock later.
// - Claims come only from positive decode, never subtractive.
`ifndef PBCH_DEFS_SVH
`define PBCH_DEFS_SVH

`define PBCH_CMD_INTACK   4'h0
`define PBCH_CMD_SPECIAL  4'h1
`define PBCH_CMD_IORD     4'h2
`define PBCH_CMD_IOWR     4'h3
`define PBCH_CMD_RSV4     4'h4
`define PBCH_CMD_RSV5     4'h5
`define PBCH_CMD_MEMRD    4'h6
`define PBCH_CMD_MEMWR    4'h7
`define PBCH_CMD_RSV8     4'h8
`define PBCH_CMD_RSV9     4'h9
`define PBCH_CMD_CFGRD    4'ha
`define PBCH_CMD_CFGWR    4'hb
`define PBCH_CMD_MEMRDM   4'hc
`define PBCH_CMD_DAC      4'hd
`define PBCH_CMD_MEMRDL   4'he
`define PBCH_CMD_MEMWI    4'hf

// Low address bits carrying the burst order
`define PBCH_BURST_MSB    1
`define PBCH_BURST_LSB    0
`define PBCH_BURST_LINEAR 2'h0

// Config address type field: AD[1:0] = 01 marks Type-1
`define PBCH_CFG_TYPE1    2'h1

`define PBCH_CMD_RST      4'h0
`define PBCH_ADDR_RST     32'h0000_0000

`endif

/* File: hw/pbch_pkg.sv */
/*
 Types shared by the bridge command policy modules.
 Assumes the constants header sits beside it.
*/
package pbch_pkg;

    typedef logic [3:0] pbch_cmd_t;

    // Address-phase tracker, Gray coded along idle, first, second, data
    typedef enum logic [1:0] {
        PBCH_IDLE   = 2'b00,
        PBCH_ADDR1  = 2'b01,
        PBCH_ADDR2  = 2'b11,
        PBCH_DATA   = 2'b10
    } pbch_phase_e;

endpackage

/* File: hw/pbch_policy.sv */
/*
 Combinational command policy table: for one command code and bus side it tells
 whether the bridge may claim it as target and whether it may issue it as master.
 Assumes the caller supplies the code live, from the stage-three word or the master request.
*/
`include "pbch_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pbch_policy (
    input  wire logic [3:0] cmd,
    input  wire logic       secondary,
    input  wire logic       cfg_type1,
    output logic            claim_ok,
    output logic            master_ok
);

    // ----------------------------------------------------------------
    // Policy table
    // ----------------------------------------------------------------
    // Table lookup over every code; default refuses both roles
    always_comb begin
        claim_ok  = 1'b0;
        master_ok = 1'b0;
        case (cmd)
            `PBCH_CMD_INTACK: begin
                claim_ok  = 1'b0;
                master_ok = 1'b0;
            end
            `PBCH_CMD_SPECIAL: begin
                claim_ok  = 1'b0;
                master_ok = 1'b1;
            end
            `PBCH_CMD_IORD, `PBCH_CMD_IOWR, `PBCH_CMD_MEMRD, `PBCH_CMD_MEMWR: begin
                claim_ok  = 1'b1;
                master_ok = 1'b1;
            end
            `PBCH_CMD_CFGRD: begin
                claim_ok  = !secondary;
                master_ok = secondary;
            end
            `PBCH_CMD_CFGWR: begin
                claim_ok  = !secondary || cfg_type1;
                master_ok = secondary || cfg_type1;
            end
            `PBCH_CMD_MEMRDM, `PBCH_CMD_DAC, `PBCH_CMD_MEMRDL: begin
                claim_ok  = 1'b1;
                master_ok = 1'b1;
            end
            `PBCH_CMD_MEMWI: begin
                claim_ok  = 1'b1;
                master_ok = 1'b1;
            end
            default: begin
                claim_ok  = 1'b0;
                master_ok = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: hw/pbch_bridge_cmd.sv */
/*
 Command acceptance and generation policy for one bus side of a bridge.
 Watches frame and the address phase, latches command and address, decides claim,
 handles the dual address cycle and flags non-linear bursts for disconnect.
 Also gates the master command path so only allowed codes reach the bus.
 Assumes bus pins are already in this clock domain for the master path, and that
 the frame and command pins come straight from the bus (they are synchronised here).
*/
`include "pbch_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pbch_bridge_cmd (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        secondary,
    input  wire logic        frame_n,
    input  wire logic [31:0] addr_data,
    input  wire logic [3:0]  primary_command_byte_enables,
    input  wire logic        addr_hit,
    input  wire logic        mst_req,
    input  wire logic [3:0]  mst_cmd,
    input  wire logic [31:0] mst_addr,
    input  wire logic        first_xfer_done,
    output logic             claim,
    output logic             ignore,
    output logic [3:0]       lat_cmd,
    output logic [31:0]      lat_addr,
    output logic             dac_active,
    output logic             disconnect,
    output logic             mst_grant,
    output logic             mst_refused,
    output logic [31:0]      mst_ad_out,
    output logic [3:0]       mst_cbe_out
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0]  frame_sync_ff;
    logic [2:0]  nxt_frame_sync;
    logic [35:0] bus_s1_ff;
    logic [35:0] bus_s2_ff;
    logic [35:0] bus_s3_ff;
    logic [35:0] nxt_bus_s1;
    logic [35:0] nxt_bus_s2;
    logic [35:0] nxt_bus_s3;
    logic        frame_ff;
    logic        nxt_frame;
    logic        frame_act;
    logic [3:0]  bus_cmd;
    logic [31:0] bus_addr;

    // Three stages; a change is taken once stages two and three agree
    always_comb begin
        nxt_frame_sync = {frame_sync_ff[1:0], !frame_n};
        nxt_bus_s1     = {primary_command_byte_enables, addr_data};
        nxt_bus_s2     = bus_s1_ff;
        nxt_bus_s3     = bus_s2_ff;
        nxt_frame      = frame_ff;
        if (frame_sync_ff[1] == frame_sync_ff[2]) begin
            nxt_frame = frame_sync_ff[2];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            frame_sync_ff <= 3'h0;
            bus_s1_ff     <= 36'h0_0000_0000;
            bus_s2_ff     <= 36'h0_0000_0000;
            bus_s3_ff     <= 36'h0_0000_0000;
            frame_ff      <= 1'b0;
        end else begin
            frame_sync_ff <= nxt_frame_sync;
            bus_s1_ff     <= nxt_bus_s1;
            bus_s2_ff     <= nxt_bus_s2;
            bus_s3_ff     <= nxt_bus_s3;
            frame_ff      <= nxt_frame;
        end
    end

    // Agreed frame is used as it forms; registering it first would put it one word late
    assign frame_act = nxt_frame;
    assign bus_cmd   = bus_s3_ff[35:32];
    assign bus_addr  = bus_s3_ff[31:0];

    // ----------------------------------------------------------------
    // Target decision
    // ----------------------------------------------------------------
    pbch_pkg::pbch_phase_e phase_ff;
    pbch_pkg::pbch_phase_e nxt_phase;
    logic        claim_ok;
    logic        cfg_type1;
    logic [3:0]  dec_cmd;
    logic        claim_ff;
    logic        nxt_claim;
    logic        ignore_ff;
    logic        nxt_ignore;
    logic [3:0]  lat_cmd_ff;
    logic [3:0]  nxt_lat_cmd;
    logic [31:0] lat_addr_ff;
    logic [31:0] nxt_lat_addr;
    logic        dac_ff;
    logic        nxt_dac;
    logic        disc_ff;
    logic        nxt_disc;
    logic        nonlinear_ff;
    logic        nxt_nonlinear;

    function automatic logic is_linear(input logic [31:0] a);
        is_linear = (a[`PBCH_BURST_MSB:`PBCH_BURST_LSB] == `PBCH_BURST_LINEAR);
    endfunction

    // Low address bits 01 mark a Type-1 configuration access
    function automatic logic is_type1(input logic [31:0] a);
        is_type1 = (a[1:0] == `PBCH_CFG_TYPE1);
    endfunction

    // Both decision points read the stage-three word; the latch path would loop back
    assign dec_cmd   = bus_cmd;
    assign cfg_type1 = is_type1(lat_addr_ff);

    pbch_policy u_tgt_policy (
        .cmd       (dec_cmd),
        .secondary (secondary),
        .cfg_type1 ((phase_ff == pbch_pkg::PBCH_IDLE) ? is_type1(bus_addr) : cfg_type1),
        .claim_ok  (claim_ok),
        .master_ok ()
    );

    // Address phase sequencing, latch, claim and burst check
    always_comb begin
        nxt_phase     = phase_ff;
        nxt_lat_cmd   = lat_cmd_ff;
        nxt_lat_addr  = lat_addr_ff;
        nxt_claim     = claim_ff;
        nxt_ignore    = ignore_ff;
        nxt_dac       = dac_ff;
        nxt_disc      = disc_ff;
        nxt_nonlinear = nonlinear_ff;
        case (phase_ff)
            pbch_pkg::PBCH_IDLE: begin
                nxt_claim  = 1'b0;
                nxt_ignore = 1'b0;
                nxt_disc   = 1'b0;
                nxt_dac    = 1'b0;
                if (frame_act && !frame_ff) begin
                    nxt_lat_cmd  = bus_cmd;
                    nxt_lat_addr = bus_addr;
                    nxt_nonlinear = !is_linear(bus_addr);
                    if (bus_cmd == `PBCH_CMD_DAC) begin
                        nxt_phase = pbch_pkg::PBCH_ADDR2;
                        nxt_dac   = 1'b1;
                    end else begin
                        nxt_phase = pbch_pkg::PBCH_DATA;
                        nxt_claim  = claim_ok && addr_hit;
                        nxt_ignore = !(claim_ok && addr_hit);
                    end
                end
            end
            pbch_pkg::PBCH_ADDR2: begin
                nxt_lat_cmd = bus_cmd;
                nxt_phase   = pbch_pkg::PBCH_DATA;
                nxt_claim   = claim_ok && addr_hit && (bus_cmd != `PBCH_CMD_DAC);
                nxt_ignore  = !(claim_ok && addr_hit && (bus_cmd != `PBCH_CMD_DAC));
            end
            pbch_pkg::PBCH_DATA: begin
                if (claim_ff && nonlinear_ff && first_xfer_done) begin
                    nxt_disc = 1'b1;
                end
                if (!frame_act) begin
                    nxt_phase = pbch_pkg::PBCH_IDLE;
                end
            end
            default: begin
                nxt_phase = pbch_pkg::PBCH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            phase_ff     <= pbch_pkg::PBCH_IDLE;
            lat_cmd_ff   <= `PBCH_CMD_RST;
            lat_addr_ff  <= `PBCH_ADDR_RST;
            claim_ff     <= 1'b0;
            ignore_ff    <= 1'b0;
            dac_ff       <= 1'b0;
            disc_ff      <= 1'b0;
            nonlinear_ff <= 1'b0;
        end else begin
            phase_ff     <= nxt_phase;
            lat_cmd_ff   <= nxt_lat_cmd;
            lat_addr_ff  <= nxt_lat_addr;
            claim_ff     <= nxt_claim;
            ignore_ff    <= nxt_ignore;
            dac_ff       <= nxt_dac;
            disc_ff      <= nxt_disc;
            nonlinear_ff <= nxt_nonlinear;
        end
    end

    assign claim      = claim_ff;
    assign ignore     = ignore_ff;
    assign lat_cmd    = lat_cmd_ff;
    assign lat_addr   = lat_addr_ff;
    assign dac_active = dac_ff;
    assign disconnect = disc_ff;

    // ----------------------------------------------------------------
    // Master command gate
    // ----------------------------------------------------------------
    logic        mst_ok;
    logic [31:0] mst_ad_ff;
    logic [31:0] nxt_mst_ad;
    logic [3:0]  mst_cbe_ff;
    logic [3:0]  nxt_mst_cbe;
    logic        mst_ref_ff;
    logic        nxt_mst_ref;

    pbch_policy u_mst_policy (
        .cmd       (mst_cmd),
        .secondary (secondary),
        .cfg_type1 (is_type1(mst_addr)),
        .claim_ok  (),
        .master_ok (mst_ok)
    );

    // Refused codes never reach the lines; old values are held instead
    always_comb begin
        nxt_mst_ad  = mst_ad_ff;
        nxt_mst_cbe = mst_cbe_ff;
        nxt_mst_ref = 1'b0;
        if (mst_req) begin
            if (mst_ok) begin
                nxt_mst_ad  = mst_addr;
                nxt_mst_cbe = mst_cmd;
            end else begin
                nxt_mst_ref = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mst_ad_ff  <= `PBCH_ADDR_RST;
            mst_cbe_ff <= `PBCH_CMD_RST;
            mst_ref_ff <= 1'b0;
        end else begin
            mst_ad_ff  <= nxt_mst_ad;
            mst_cbe_ff <= nxt_mst_cbe;
            mst_ref_ff <= nxt_mst_ref;
        end
    end

    assign mst_grant   = mst_req && mst_ok;
    assign mst_refused = mst_ref_ff;
    assign mst_ad_out  = mst_ad_ff;
    assign mst_cbe_out = mst_cbe_ff;

endmodule

`default_nettype wire

/* File: testbench/pbch_bridge_cmd_assertions.sv */
/*
 Port-level checker for the bridge command policy block.
 Assumes one clock, reset low, and a bind onto every instance.
*/
`timescale 1ns/1ns
`default_nettype none

module pbch_cmd_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        secondary,
    input wire logic        frame_n,
    input wire logic        addr_hit,
    input wire logic        mst_req,
    input wire logic [3:0]  mst_cmd,
    input wire logic [31:0] mst_addr,
    input wire logic        first_xfer_done,
    input wire logic        claim,
    input wire logic        ignore,
    input wire logic [3:0]  lat_cmd,
    input wire logic [31:0] lat_addr,
    input wire logic        dac_active,
    input wire logic        disconnect,
    input wire logic        mst_grant,
    input wire logic        mst_refused,
    input wire logic [31:0] mst_ad_out,
    input wire logic [3:0]  mst_cbe_out
);
    // ----------------------------------------
    // Target and master decisions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_one_verdict: assert property (!(claim && ignore))
        else $error("claim and ignore together");
    chk_no_intack: assert property (claim |-> lat_cmd != 4'h0)
        else $error("interrupt acknowledge claimed");
    chk_no_rsvd: assert property (claim |-> !(lat_cmd inside {4'h1, 4'h4, 4'h5, 4'h8, 4'h9}))
        else $error("reserved or special command claimed");
    chk_cfg_read: assert property (claim && lat_cmd == 4'ha |-> !secondary)
        else $error("config read claimed on secondary");
    chk_cfg_write: assert property (claim && secondary && lat_cmd == 4'hb |-> lat_addr[1:0] == 2'h1)
        else $error("type 0 config write claimed on secondary");
    chk_mst_gate: assert property (mst_grant |-> mst_req && !(mst_cmd inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9}))
        else $error("forbidden command granted");
    chk_mst_type0: assert property (mst_grant && !secondary && mst_cmd[3:1] == 3'h5 |-> mst_cmd == 4'hb && mst_addr[1:0] == 2'h1)
        else $error("primary config master not type 1 write");
    chk_mst_drive: assert property (mst_grant |=> mst_cbe_out == $past(mst_cmd) && mst_ad_out == $past(mst_addr))
        else $error("granted command not driven");
    chk_refuse_pulse: assert property (mst_refused == ($past(mst_req && !mst_grant) && $past(nrst)))
        else $error("refusal pulse wrong");
    chk_disc_cause: assert property ($rose(disconnect) |-> claim && lat_addr[1:0] != 2'h0 && $past(first_xfer_done))
        else $error("disconnect without cause");
    chk_linear_keep: assert property (claim && lat_addr[1:0] == 2'h0 |-> !disconnect)
        else $error("linear burst disconnected");
    chk_dac_second: assert property (dac_active && claim |-> lat_cmd != 4'hd)
        else $error("nested dual address claimed");
    chk_claim_hit: assert property ($rose(claim) |-> $past(addr_hit))
        else $error("claim without decode hit");
endmodule

bind pbch_bridge_cmd pbch_cmd_checker u_chk (
    .clock           (clock),
    .nrst            (nrst),
    .secondary       (secondary),
    .frame_n         (frame_n),
    .addr_hit        (addr_hit),
    .mst_req         (mst_req),
    .mst_cmd         (mst_cmd),
    .mst_addr        (mst_addr),
    .first_xfer_done (first_xfer_done),
    .claim           (claim),
    .ignore          (ignore),
    .lat_cmd         (lat_cmd),
    .lat_addr        (lat_addr),
    .dac_active      (dac_active),
    .disconnect      (disconnect),
    .mst_grant       (mst_grant),
    .mst_refused     (mst_refused),
    .mst_ad_out      (mst_ad_out),
    .mst_cbe_out     (mst_cbe_out)
);

`default_nettype wire

/* File: testbench/pbch_initiator.sv */
/*
 Behavioural bus initiator: one transaction per go request, optional dual address.
 Assumes go is raised at a falling edge and dropped one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none

module pbch_initiator (
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic        dac,
    input  wire logic [3:0]  cmd,
    input  wire logic [3:0]  cmd2,
    input  wire logic [31:0] addr,
    output logic             frame_n,
    output logic [31:0]      addr_data,
    output logic [3:0]       primary_command_byte_enables
);
    logic go_q;
    int   cnt;

    // Request seen on the rising edge, so the falling-edge drive never races it
    always @(posedge clock) go_q <= go;

    // Bus drive on falling edges; idle lines keep moving so stale values mean nothing
    initial begin
        frame_n = 1'b1;
        addr_data = 32'h0;
        primary_command_byte_enables = 4'h0;
        cnt = 0;
        forever begin
            @(negedge clock);
            if (cnt == 0) begin
                if (go_q) begin
                    frame_n = 1'b0;
                    addr_data = addr;
                    primary_command_byte_enables = cmd;
                    cnt = 1;
                end else begin
                    addr_data = ~addr_data;
                    primary_command_byte_enables = ~primary_command_byte_enables;
                end
            end else begin
                cnt++;
                if (cnt == 2 && dac) begin
                    addr_data = ~addr;
                    primary_command_byte_enables = cmd2;
                end else if (cnt < 14) begin
                    addr_data = addr_data + 32'h1111_1111;
                    primary_command_byte_enables = 4'h0;
                end else begin
                    frame_n = 1'b1;
                    cnt = 0;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* File: testbench/pbch_bridge_cmd_tb.sv */
/*
 Self-checking bench for the bridge command policy block.
 Assumes the initiator model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module pbch_bridge_cmd_tb;
    logic        clock = 1'b0, nrst = 1'b0, secondary = 1'b0, addr_hit = 1'b0;
    logic        mst_req = 1'b0, first_xfer_done = 1'b0, go = 1'b0, dac = 1'b0;
    logic [3:0]  mst_cmd = 4'h0, cmd = 4'h0, cmd2 = 4'h0;
    logic [31:0] mst_addr = 32'h0, addr = 32'h0;
    logic        frame_n, claim, ignore, dac_active, disconnect, mst_grant, mst_refused;
    logic [3:0]  primary_command_byte_enables, lat_cmd, mst_cbe_out;
    logic [31:0] addr_data, lat_addr, mst_ad_out;
    int          failures = 0, num_checks = 0;

    pbch_bridge_cmd u_dut (
        .clock                        (clock),
        .nrst                         (nrst),
        .secondary                    (secondary),
        .frame_n                      (frame_n),
        .addr_data                    (addr_data),
        .primary_command_byte_enables (primary_command_byte_enables),
        .addr_hit                     (addr_hit),
        .mst_req                      (mst_req),
        .mst_cmd                      (mst_cmd),
        .mst_addr                     (mst_addr),
        .first_xfer_done              (first_xfer_done),
        .claim                        (claim),
        .ignore                       (ignore),
        .lat_cmd                      (lat_cmd),
        .lat_addr                     (lat_addr),
        .dac_active                   (dac_active),
        .disconnect                   (disconnect),
        .mst_grant                    (mst_grant),
        .mst_refused                  (mst_refused),
        .mst_ad_out                   (mst_ad_out),
        .mst_cbe_out                  (mst_cbe_out)
    );

    pbch_initiator u_init (
        .clock                        (clock),
        .go                           (go),
        .dac                          (dac),
        .cmd                          (cmd),
        .cmd2                         (cmd2),
        .addr                         (addr),
        .frame_n                      (frame_n),
        .addr_data                    (addr_data),
        .primary_command_byte_enables (primary_command_byte_enables)
    );

    // ----------------------------------------
    // Clock, compare and verdict
    // ----------------------------------------
    always #5 clock = ~clock;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Claim table for the target side, written out independently of the design
    function automatic logic tgt_ok(logic [3:0] c, logic s, logic t1);
        case (c)
            4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf: return 1'b1;
            4'ha: return !s;
            4'hb: return !s || t1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic mst_ok(logic [3:0] c, logic s, logic t1);
        case (c)
            4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf: return 1'b1;
            4'ha: return s;
            4'hb: return s || t1;
            default: return 1'b0;
        endcase
    endfunction

    // One transaction from the initiator, judged through claim and disconnect
    task automatic xfer(logic [3:0] c, logic [3:0] c2, logic d, logic [31:0] a, logic h, logic s);
        logic e;
        secondary = s;
        addr_hit = h;
        cmd = c;
        cmd2 = c2;
        dac = d;
        addr = a;
        go = 1'b1;
        @(negedge clock);
        go = 1'b0;
        e = h && (d ? (c2 != 4'hd && tgt_ok(c2, s, a[1:0] == 2'h1)) : tgt_ok(c, s, a[1:0] == 2'h1));
        for (int n = 0; n < 12 && claim !== 1'b1 && ignore !== 1'b1; n++) @(negedge clock);
        check("claim", claim, e);
        check("ignore", ignore, !e);
        check("lat_cmd", lat_cmd, d ? c2 : c);
        check("lat_addr", lat_addr, a);
        check("dac_active", dac_active, d);
        check("disconnect early", disconnect, 1'b0);
        first_xfer_done = 1'b1;
        @(negedge clock);
        first_xfer_done = 1'b0;
        @(negedge clock);
        check("disconnect", disconnect, e && a[1:0] != 2'h0);
        for (int n = 0; n < 30 && (claim !== 1'b0 || ignore !== 1'b0); n++) @(negedge clock);
        check("idle", {claim, ignore}, 2'h0);
        repeat (4) @(negedge clock);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        check("reset outs", {claim, ignore, disconnect, mst_refused, lat_cmd, mst_cbe_out}, 12'h0);
    endtask

    // Every code on both sides, aligned and type 1 addresses; code d runs as dual address
    task automatic test_target_table();
        for (int i = 0; i < 64; i++) xfer(i[3:0], 4'h6, i[3:0] == 4'hd, 32'h1000 | 32'(i[5]), 1'b1, i[4]);
    endtask

    task automatic test_odd_cases();
        xfer(4'hd, 4'hd, 1'b1, 32'h2000, 1'b1, 1'b0);
        xfer(4'h7, 4'h0, 1'b0, 32'h3002, 1'b0, 1'b1);
        xfer(4'he, 4'h0, 1'b0, 32'h3003, 1'b1, 1'b0);
    endtask

    // Back-to-back master requests; refused ones must leave the drive untouched
    task automatic test_master();
        logic [3:0]  last_c;
        logic [31:0] last_a;
        logic        e;
        last_c = 4'h0;
        last_a = 32'h0;
        for (int i = 0; i < 64; i++) begin
            mst_req = 1'b1;
            mst_cmd = i[3:0];
            secondary = i[4];
            mst_addr = 32'h2000 + 32'(i * 4) + 32'(i[5]);
            e = mst_ok(i[3:0], i[4], i[5]);
            #1;
            check("mst_grant", mst_grant, e);
            @(negedge clock);
            check("mst_refused", mst_refused, !e);
            if (e) begin
                last_c = mst_cmd;
                last_a = mst_addr;
            end
            check("mst_cbe_out", mst_cbe_out, last_c);
            check("mst_ad_out", mst_ad_out, last_a);
        end
        mst_req = 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        test_reset();
        repeat (4) @(negedge clock);
        test_target_table();
        test_odd_cases();
        test_master();
        give_verdict();
    end

    // Generous bound: the full run needs about 1620 cycles
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule

`default_nettype wire
